/* File: core/rxaf_defines.svh */
// constants of the receive address filter and wake-up frame detector
`ifndef RXAF_DEFINES_SVH
`define RXAF_DEFINES_SVH

`define RXAF_OFS_MAC_CONTROL 8'h00
`define RXAF_OFS_ADDR_HIGH 8'h04
`define RXAF_OFS_ADDR_LOW 8'h08
`define RXAF_OFS_HASH_HIGH 8'h0c
`define RXAF_OFS_HASH_LOW 8'h10
`define RXAF_OFS_WAKE_CS 8'h14
`define RXAF_OFS_WAKE_PORT 8'h18

`define RXAF_CTL_PASS_MC 0
`define RXAF_CTL_ACCEPT_ALL 1
`define RXAF_CTL_INVERSE 2
`define RXAF_CTL_HASH_ONLY 3
`define RXAF_CTL_HASH_PERF 4
`define RXAF_CTL_WIDTH 5

`define RXAF_WCS_ENABLE 0
`define RXAF_WCS_RECEIVED 1
`define RXAF_WCS_IRQ_EN 2
`define RXAF_WCS_PME_EN 3

`define RXAF_FCMD_ENABLE 0
`define RXAF_FCMD_MCAST 3
`define RXAF_MASK_BITS 31
`define RXAF_WORD_CMD 3'h4
`define RXAF_WORD_OFS 3'h5
`define RXAF_WORD_CRC10 3'h6
`define RXAF_WORD_CRC32 3'h7

`define RXAF_DA_LAST 8'h05
`define RXAF_CNT_MAX 8'hff
`define RXAF_CRC32_INIT 32'hffffffff
`define RXAF_CRC32_POLY 32'hedb88320
`define RXAF_CRC16_INIT 16'hffff
`define RXAF_CRC16_POLY 16'ha001

`endif

/* File: core/rxaf_pkg.sv */
// types of the receive address filter and wake-up frame detector
package rxaf_pkg;
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
    } rxaf_rx_s;

    typedef struct packed {
        logic valid;
        logic pass;
        logic mcast;
    } rxaf_dec_s;

    typedef enum logic [1:0] {
        FR_IDLE,
        FR_ADDR,
        FR_BODY
    } rxaf_frame_e;
endpackage

/* File: core/rxaf_top.sv */
// receive address filter and wake-up frame detector with AHB-Lite registers
`timescale 1ns/1ps
`include "rxaf_defines.svh"

module rxaf_top #(
    parameter int NUM_FILTERS = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire rxaf_pkg::rxaf_rx_s rx_in,
    input wire logic pwr_state_d1,
    output rxaf_pkg::rxaf_dec_s addr_dec,
    output logic rx_accept,
    output logic host_irq,
    output logic power_event_output
);

    function automatic logic [31:0] crc32_byte(input logic [31:0] c,
                                               input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int b = 0; b < 8; b++) begin
            r = (r[0] ^ d[b]) ? ((r >> 1) ^ `RXAF_CRC32_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                               input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int b = 0; b < 8; b++) begin
            r = (r[0] ^ d[b]) ? ((r >> 1) ^ `RXAF_CRC16_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // bus slave: zero wait states, always OKAY
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [`RXAF_CTL_WIDTH-1:0] mac_control_reg;
    logic [15:0] addr_high_reg;
    logic [31:0] addr_low_reg;
    logic [31:0] hash_high_reg;
    logic [31:0] hash_low_reg;
    logic wake_frame_enable_reg;
    logic wake_frame_received_flag_reg;
    logic irq_en_reg;
    logic pme_en_reg;
    logic [31:0] wf_reg [0:7];
    logic [2:0] wf_ptr_reg;
    logic host_irq_reg;
    logic pme_reg;

    wire addr_ph = hsel & htrans[1] & hready;
    wire [7:0] a_ofs = {haddr[7:2], 2'b00};
    wire wr_ctl = wr_pend_reg && wr_addr_reg == `RXAF_OFS_MAC_CONTROL;
    wire wr_ahi = wr_pend_reg && wr_addr_reg == `RXAF_OFS_ADDR_HIGH;
    wire wr_alo = wr_pend_reg && wr_addr_reg == `RXAF_OFS_ADDR_LOW;
    wire wr_hhi = wr_pend_reg && wr_addr_reg == `RXAF_OFS_HASH_HIGH;
    wire wr_hlo = wr_pend_reg && wr_addr_reg == `RXAF_OFS_HASH_LOW;
    wire wr_wcs = wr_pend_reg && wr_addr_reg == `RXAF_OFS_WAKE_CS;
    wire wr_wport = wr_pend_reg && wr_addr_reg == `RXAF_OFS_WAKE_PORT;

    wire [31:0] wcs_word = {28'h0000000, pme_en_reg, irq_en_reg,
                            wake_frame_received_flag_reg,
                            wake_frame_enable_reg};
    wire [31:0] rd_mux =
        (a_ofs == `RXAF_OFS_MAC_CONTROL) ? {27'h0000000, mac_control_reg} :
        (a_ofs == `RXAF_OFS_ADDR_HIGH) ? {16'h0000, addr_high_reg} :
        (a_ofs == `RXAF_OFS_ADDR_LOW) ? addr_low_reg :
        (a_ofs == `RXAF_OFS_HASH_HIGH) ? hash_high_reg :
        (a_ofs == `RXAF_OFS_HASH_LOW) ? hash_low_reg :
        (a_ofs == `RXAF_OFS_WAKE_CS) ? wcs_word :
        (a_ofs == `RXAF_OFS_WAKE_PORT) ? wf_reg[wf_ptr_reg] :
        32'h00000000;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
        end else begin
            wr_pend_reg <= addr_ph & hwrite;
            wr_addr_reg <= a_ofs;
            if (addr_ph && !hwrite) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mac_control_reg <= '0;
            addr_high_reg <= 16'h0000;
            addr_low_reg <= 32'h00000000;
            hash_high_reg <= 32'h00000000;
            hash_low_reg <= 32'h00000000;
        end else begin
            if (wr_ctl) mac_control_reg <= hwdata[`RXAF_CTL_WIDTH-1:0];
            if (wr_ahi) addr_high_reg <= hwdata[15:0];
            if (wr_alo) addr_low_reg <= hwdata;
            if (wr_hhi) hash_high_reg <= hwdata;
            if (wr_hlo) hash_low_reg <= hwdata;
        end
    end

    // filter port: each write fills the next word, pointer wraps after 8
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wf_ptr_reg <= 3'h0;
            for (int i = 0; i < 8; i++) wf_reg[i] <= 32'h00000000;
        end else if (wr_wport) begin
            wf_reg[wf_ptr_reg] <= hwdata;
            wf_ptr_reg <= wf_ptr_reg + 3'h1;
        end
    end

    // frame tracking
    rxaf_pkg::rxaf_frame_e st_reg;
    logic [7:0] cnt_reg;
    logic [47:0] da_reg;
    logic [31:0] crc32_reg;
    logic mc_reg;
    logic pass_reg;
    logic [15:0] crc16_reg [NUM_FILTERS];
    rxaf_pkg::rxaf_dec_s dec_reg;

    wire beat = rx_in.valid;
    wire [7:0] cur_idx = rx_in.sof ? 8'h00 : cnt_reg;
    wire in_frame = rx_in.sof || st_reg != rxaf_pkg::FR_IDLE;
    wire da_beat = beat && in_frame && cur_idx <= `RXAF_DA_LAST;
    wire da_done = beat && in_frame && cur_idx == `RXAF_DA_LAST;
    wire mc_now = (rx_in.sof) ? rx_in.data[0] : mc_reg;
    wire [47:0] da_next = {rx_in.data, da_reg[47:8]};
    wire [31:0] crc32_next =
        crc32_byte(rx_in.sof ? `RXAF_CRC32_INIT : crc32_reg, rx_in.data);
    wire [5:0] hash_idx = crc32_next[31:26];
    wire hash_hit = hash_idx[5] ? hash_high_reg[hash_idx[4:0]]
                                : hash_low_reg[hash_idx[4:0]];
    wire perfect_hit = da_next == {addr_high_reg, addr_low_reg};

    wire c_pam = mac_control_reg[`RXAF_CTL_PASS_MC];
    wire c_all = mac_control_reg[`RXAF_CTL_ACCEPT_ALL];
    wire c_inv = mac_control_reg[`RXAF_CTL_INVERSE];
    wire c_ho = mac_control_reg[`RXAF_CTL_HASH_ONLY];
    wire c_hp = mac_control_reg[`RXAF_CTL_HASH_PERF];
    wire hash_all = c_ho & c_hp;

    // odd mixes fall to the first arm that fits, accept-all first
    wire addr_pass =
        c_all ? 1'b1 :
        c_inv ? !perfect_hit :
        (mc_now && c_pam) ? 1'b1 :
        hash_all ? hash_hit :
        (mc_now && c_hp) ? hash_hit :
        perfect_hit;

    // D1 forces detection on whatever software wrote
    wire wake_active = wake_frame_enable_reg | pwr_state_d1;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_reg <= rxaf_pkg::FR_IDLE;
            cnt_reg <= 8'h00;
        end else if (beat && in_frame) begin
            cnt_reg <= (cur_idx == `RXAF_CNT_MAX) ? cur_idx
                                                  : cur_idx + 8'h01;
            if (rx_in.eof) begin
                st_reg <= rxaf_pkg::FR_IDLE;
            end else if (da_done) begin
                st_reg <= rxaf_pkg::FR_BODY;
            end else if (rx_in.sof) begin
                st_reg <= rxaf_pkg::FR_ADDR;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            da_reg <= 48'h000000000000;
            crc32_reg <= `RXAF_CRC32_INIT;
            mc_reg <= 1'b0;
            pass_reg <= 1'b0;
        end else if (da_beat) begin
            da_reg <= da_next;
            crc32_reg <= crc32_next;
            mc_reg <= mc_now;
            pass_reg <= da_done & addr_pass;
        end
    end

    // per-filter masked CRC-16 over the bytes after each offset
    logic [15:0] crc16_next [NUM_FILTERS];
    logic [NUM_FILTERS-1:0] f_hit;
    always_comb begin
        logic [15:0] c;
        logic [7:0] fofs;
        logic [8:0] rel;
        logic [7:0] fcmd;
        c = 16'h0000;
        fofs = 8'h00;
        rel = 9'h000;
        fcmd = 8'h00;
        for (int i = 0; i < NUM_FILTERS; i++) begin
            c = rx_in.sof ? `RXAF_CRC16_INIT : crc16_reg[i];
            fofs = wf_reg[`RXAF_WORD_OFS][8*i +: 8];
            fcmd = wf_reg[`RXAF_WORD_CMD][8*i +: 8];
            rel = {1'b0, cur_idx} - {1'b0, fofs};
            // mask bit 31 is never looked at
            if (cur_idx >= fofs && rel < 9'(`RXAF_MASK_BITS) &&
                wf_reg[i][rel[4:0]]) begin
                c = crc16_byte(c, rx_in.data);
            end
            crc16_next[i] = c;
            f_hit[i] = fcmd[`RXAF_FCMD_ENABLE] &&
                (fcmd[`RXAF_FCMD_MCAST] == mc_reg) &&
                (c == wf_reg[`RXAF_WORD_CRC10 + 3'(i >> 1)]
                    [16*(i & 1) +: 16]);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_FILTERS; i++) begin
                crc16_reg[i] <= `RXAF_CRC16_INIT;
            end
        end else if (beat && in_frame) begin
            for (int i = 0; i < NUM_FILTERS; i++) begin
                crc16_reg[i] <= crc16_next[i];
            end
        end
    end

    // only frames that passed address filtering can wake
    wire wake_hit = wake_active && beat && rx_in.eof && !rx_in.sof &&
        st_reg == rxaf_pkg::FR_BODY && pass_reg && |f_hit;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wake_frame_enable_reg <= 1'b0;
            wake_frame_received_flag_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            pme_en_reg <= 1'b0;
        end else begin
            if (wr_wcs) begin
                wake_frame_enable_reg <= hwdata[`RXAF_WCS_ENABLE];
                irq_en_reg <= hwdata[`RXAF_WCS_IRQ_EN];
                pme_en_reg <= hwdata[`RXAF_WCS_PME_EN];
            end
            // a new wake frame wins over a same-cycle clear
            if (wake_hit) begin
                wake_frame_received_flag_reg <= 1'b1;
            end else if (wr_wcs && hwdata[`RXAF_WCS_RECEIVED]) begin
                wake_frame_received_flag_reg <= 1'b0;
            end
        end
    end

    // decision pulse; reception is gated off in wake mode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dec_reg <= '0;
            host_irq_reg <= 1'b0;
            pme_reg <= 1'b0;
        end else begin
            dec_reg.valid <= da_done;
            dec_reg.pass <= da_done & addr_pass & !wake_active;
            dec_reg.mcast <= da_done & mc_now;
            host_irq_reg <= wake_frame_received_flag_reg & irq_en_reg;
            pme_reg <= wake_frame_received_flag_reg & pme_en_reg;
        end
    end

    assign addr_dec = dec_reg;
    assign rx_accept = pass_reg & !wake_active &
                       st_reg == rxaf_pkg::FR_BODY;
    assign host_irq = host_irq_reg;
    assign power_event_output = pme_reg;

endmodule

/* File: bench/rxaf_chk.sv */
// concurrent checks on the receive-side ports of the filter
`timescale 1ns/1ps
module rxaf_chk #(
    parameter int NUM_FILTERS = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire rxaf_pkg::rxaf_rx_s rx_in,
    input wire logic pwr_state_d1,
    input wire rxaf_pkg::rxaf_dec_s addr_dec,
    input wire logic rx_accept
);
    logic first_bit_reg;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    always_ff @(posedge mclk) begin
        if (sys_rst)
            first_bit_reg <= 1'b0;
        else if (rx_in.valid && rx_in.sof)
            first_bit_reg <= rx_in.data[0];
    end
    sequence da_start;
        rx_in.valid && rx_in.sof && !rx_in.eof;
    endsequence
    sequence da_rest;
        (rx_in.valid && !rx_in.sof && !rx_in.eof) [*5];
    endsequence
    a_dec_timing: assert property (
        da_start ##1 da_rest |=> addr_dec.valid)
        else $error("no decision after sixth address byte");
    a_dec_not_early: assert property (
        rx_in.valid && rx_in.sof |=> !addr_dec.valid [*5])
        else $error("decision before address complete");
    a_dec_once: assert property (
        addr_dec.valid |=> !addr_dec.valid)
        else $error("decision pulse longer than one cycle");
    a_mcast_bit: assert property (
        addr_dec.valid |-> addr_dec.mcast == first_bit_reg)
        else $error("multicast flag differs from first bit");
    a_accept_cause: assert property (
        $rose(rx_accept) |-> addr_dec.valid && addr_dec.pass)
        else $error("accept without passing decision");
    a_accept_end: assert property (
        rx_accept && rx_in.valid && rx_in.eof |=> !rx_accept)
        else $error("accept held past end of frame");
    a_d1_no_pass: assert property (
        addr_dec.valid && pwr_state_d1 && $past(pwr_state_d1)
        |-> !addr_dec.pass)
        else $error("frame passed while in low power state");
    a_d1_quiet: assert property (
        pwr_state_d1 && $past(pwr_state_d1) && !$past(rx_accept)
        |-> !rx_accept)
        else $error("accept rose while in low power state");
endmodule

/* File: bench/rxaf_station.sv */
// remote station model: sends whole frames byte by byte
`timescale 1ns/1ps
module rxaf_station (
    input wire logic mclk,
    output rxaf_pkg::rxaf_rx_s rx_in
);
    initial rx_in = '0;
    task automatic send(input logic [7:0] q[$]);
        for (int i = 0; i < q.size(); i++) begin
            rx_in <= {1'b1, i == 0, i == q.size() - 1, q[i]};
            @(posedge mclk);
        end
        // idle data inverted so a stale byte never looks current
        rx_in <= {3'b000, ~q[q.size() - 1]};
    endtask
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the receive address filter
`timescale 1ns/1ps
module tb_top;
    localparam int NUM_FILTERS = 4;
    localparam logic [47:0] SA = 48'h5c4b3a291806;
    localparam logic [47:0] OTH = 48'h5c4b3a291802;
    localparam logic [47:0] MC = 48'h0123456789a1;
    localparam logic [47:0] BC = 48'hffffffffffff;
    localparam logic [31:0] MK = 32'h0000000b;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic pwr_state_d1 = 1'b0;
    wire hready;
    logic [31:0] hrdata;
    logic hreadyout, hresp, rx_accept, host_irq, power_event_output;
    rxaf_pkg::rxaf_rx_s rx_in;
    rxaf_pkg::rxaf_dec_s addr_dec;
    logic got_pass, got_mc, got_acc;
    logic seen_clr = 1'b0;
    int err_count = 0;
    int compares = 0;
    assign hready = hreadyout;
    always #10 mclk = ~mclk;
    rxaf_top #(.NUM_FILTERS(NUM_FILTERS)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_in(rx_in),
        .pwr_state_d1(pwr_state_d1), .addr_dec(addr_dec),
        .rx_accept(rx_accept), .host_irq(host_irq),
        .power_event_output(power_event_output));
    rxaf_station st (.mclk(mclk), .rx_in(rx_in));
    // one writer for the seen values; the frame task only asks for a clear
    always @(posedge mclk) begin
        if (seen_clr) begin
            got_pass <= 1'bx;
            got_mc <= 1'bx;
            got_acc <= 1'b0;
        end else begin
            if (addr_dec.valid === 1'b1) begin
                got_pass <= addr_dec.pass;
                got_mc <= addr_dec.mcast;
            end
            if (rx_accept === 1'b1) got_acc <= 1'b1;
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one single transfer; a trailing idle cycle keeps pairs safe
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        r = hrdata;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    function automatic logic [7:0] fb(input logic [47:0] da, input int n);
        if (n < 6) return da[8*n +: 8];
        if (n < 12) return 8'(8'ha0 + n);
        return 8'(n * 7);
    endfunction
    function automatic logic [5:0] hidx(input logic [47:0] da);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < 48; i++)
            c = (c[0] ^ da[i]) ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        return c[31:26];
    endfunction
    function automatic logic [15:0] crc16();
        logic [15:0] c;
        logic [7:0] b;
        c = 16'hffff;
        for (int j = 0; j < 31; j++) begin
            b = fb(SA, 14 + j);
            for (int k = 0; k < 8 && MK[j]; k++)
                c = (c[0] ^ b[k]) ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic sethash(input logic [47:0] da);
        logic [5:0] x;
        x = hidx(da);
        wr(8'h0c, x[5] ? 32'h1 << x[4:0] : 32'h0);
        wr(8'h10, x[5] ? 32'h0 : 32'h1 << x[4:0]);
    endtask
    task automatic load(input logic [31:0] cmd);
        logic [15:0] c;
        logic [31:0] w[8];
        c = crc16();
        w = '{MK, MK, MK, MK, cmd, 32'h0e0e0e0e, {c, c}, {c, c}};
        foreach (w[i]) wr(8'h18, w[i]);
    endtask
    task automatic frame(input logic [47:0] da, input logic exp);
        logic [7:0] q[$];
        for (int n = 0; n < 24; n++) q.push_back(fb(da, n));
        seen_clr <= 1'b1;
        @(posedge mclk);
        seen_clr <= 1'b0;
        st.send(q);
        repeat (3) @(posedge mclk);
        chk(got_pass, exp);
        chk(got_mc, da[0]);
        chk(got_acc, exp);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rdchk(8'h00, 32'h0);
        rdchk(8'h3c, 32'h0);
        wr(8'h04, {16'h0, SA[47:32]});
        wr(8'h08, SA[31:0]);
        rdchk(8'h04, {16'h0, SA[47:32]});
        frame(SA, 1'b1);
        frame(OTH, 1'b0);
        frame(MC, 1'b0);
        frame(BC, 1'b0);
        $display("test perfect done");
        sethash(MC);
        wr(8'h00, 32'h10);
        frame(MC, 1'b1);
        frame(OTH, 1'b0);
        frame(SA, 1'b1);
        wr(8'h00, 32'h18);
        frame(OTH, hidx(OTH) == hidx(MC));
        frame(SA, hidx(SA) == hidx(MC));
        frame(MC, 1'b1);
        $display("test hash done");
        wr(8'h00, 32'h04);
        frame(SA, 1'b0);
        frame(OTH, 1'b1);
        wr(8'h00, 32'h1b);
        frame(BC, 1'b1);
        frame(OTH, 1'b1);
        wr(8'h00, 32'h01);
        frame(BC, 1'b1);
        frame(OTH, 1'b0);
        wr(8'h00, 32'h19);
        frame(OTH, hidx(OTH) == hidx(MC));
        $display("test modes done");
        wr(8'h00, 32'h0);
        load(32'h00090009);
        wr(8'h14, 32'hd);
        frame(SA, 1'b0);
        rdchk(8'h14, 32'hd);
        wr(8'h14, 32'h0);
        load(32'h00000100);
        wr(8'h14, 32'hd);
        frame(SA, 1'b0);
        rdchk(8'h14, 32'hf);
        chk(host_irq, 1'b1);
        chk(power_event_output, 1'b1);
        wr(8'h14, 32'h2);
        rdchk(8'h14, 32'h0);
        chk(host_irq, 1'b0);
        chk(power_event_output, 1'b0);
        frame(SA, 1'b1);
        $display("test wake done");
        pwr_state_d1 <= 1'b1;
        frame(SA, 1'b0);
        rdchk(8'h14, 32'h2);
        pwr_state_d1 <= 1'b0;
        wr(8'h14, 32'h2);
        $display("test low power done");
        end_sim();
    end
endmodule
bind rxaf_top rxaf_chk #(.NUM_FILTERS(NUM_FILTERS)) chk_i (.mclk(mclk),
    .sys_rst(sys_rst), .rx_in(rx_in), .pwr_state_d1(pwr_state_d1),
    .addr_dec(addr_dec), .rx_accept(rx_accept));
